//--- pci_target_backend_strobes.sv
// Purpose: pci target core side of the back-end strobe interface
// Assumes: pci-side inputs already decoded and synchronous to clk
// Notes: read words are buffered; a full buffer withholds the advance strobe
`timescale 1ns/1ps

// Contract
// RL1 - hold user-write qualifier through a transaction decoded as user write at start.
// RL2 - back end writes a dword when user-write qualifier and advance strobe are both high.
// RL3 - hold config-write qualifier through the whole configuration write.
// RL4 - config logic writes a dword when config-write qualifier and advance strobe are high.
// RL5 - config logic presents the selected register on the config read bus.
// RL6 - back end presents requested user data on the back-end read bus.
// RL7 - config logic feeds command bits six and eight continuously.
// RL8 - raise parity-error-seen whenever a pci parity error is detected.
// RL9 - config logic sets status bit fifteen while parity-error-seen is high.
// RL10 - raise system-error-signalled whenever the core drives a system error.
// RL11 - config logic sets status bit fourteen while system-error-signalled is high.
// RL12 - on writes each advance pulse marks valid bus data, accepted regardless of ready.
// RL13 - back end decodes user write while the address is valid.
// RL14 - on reads a word moves when advance and ready are both high.
// RL15 - config logic keeps error flags set until written one to clear.
module pci_target_backend_strobes (
  input wire logic clk,
  input wire logic reset_n,
  // pci side, already decoded by the bus engine
  input wire logic pci_addr_phase,
  input wire logic [pci_strobe_pkg::DATA_W-1:0] pci_addr_in,
  input wire logic pci_cmd_is_write,
  input wire logic pci_cmd_is_config,
  input wire logic pci_data_valid,
  input wire logic [pci_strobe_pkg::DATA_W-1:0] pci_wr_data,
  input wire logic pci_end,
  input wire logic pci_addr_perr,
  input wire logic pci_data_perr,
  output logic pci_serr_out,
  output logic pci_perr_out,
  output logic pci_rd_valid,
  input wire logic pci_rd_ready,
  output logic [pci_strobe_pkg::DATA_W-1:0] pci_rd_data,
  // back-end side
  output logic [pci_strobe_pkg::DATA_W-1:0] addr_wrdata_bus,
  output logic addr_valid,
  output logic transfer_advance,
  output logic user_write,
  output logic config_write,
  input wire logic write_cmd_decoded,
  input wire logic backend_ready,
  input wire logic [pci_strobe_pkg::DATA_W-1:0] config_read_bus,
  input wire logic [pci_strobe_pkg::DATA_W-1:0] backend_read_bus,
  input wire logic cmd_bit_six_in,
  input wire logic cmd_bit_eight_in,
  output logic parity_error_seen,
  output logic system_error_signalled
);
  import pci_strobe_pkg::*;

  xfer_state_t state_reg;
  logic cmd_write_reg;
  logic cmd_config_reg;
  logic [DATA_W-1:0] bus_reg;
  logic addr_valid_reg;
  logic adv_wr_reg;
  logic user_write_reg;
  logic config_write_reg;
  logic perr_seen_reg;
  logic serr_reg;
  logic perr_out_reg;
  logic rd_adv;
  logic rd_push;
  logic fifo_in_ready;
  logic serr_cause;
  logic [DATA_W-1:0] rd_word;

  //////////////////////////////////////////////////////////////////////////
  // transaction sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (pci_addr_phase) begin
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_reg <= cmd_write_reg ? ST_WRITE : ST_READ;
        end
        ST_WRITE, ST_READ: begin
          if (pci_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_write_reg <= QUAL_RESET;
      cmd_config_reg <= QUAL_RESET;
    end else if (state_reg == ST_IDLE && pci_addr_phase) begin
      cmd_write_reg <= pci_cmd_is_write;
      cmd_config_reg <= pci_cmd_is_config;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address and write data share one bus
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_reg <= BUS_RESET;
      addr_valid_reg <= QUAL_RESET;
      adv_wr_reg <= QUAL_RESET;
    end else begin
      addr_valid_reg <= (state_reg == ST_IDLE) && pci_addr_phase;
      // write advance is sent even if the back end is not ready [RL12]
      adv_wr_reg <= (state_reg == ST_WRITE) && pci_data_valid;
      if (state_reg == ST_IDLE && pci_addr_phase) begin
        bus_reg <= pci_addr_in;
      end else if (state_reg == ST_WRITE && pci_data_valid) begin
        bus_reg <= pci_wr_data; // [RL12]
      end
    end
  end

  // qualifiers drop only once the final advance pulse is out
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      user_write_reg <= QUAL_RESET;
      config_write_reg <= QUAL_RESET;
    end else if (state_reg == ST_ADDR) begin
      user_write_reg <= cmd_write_reg && !cmd_config_reg && write_cmd_decoded; // [RL1]
      config_write_reg <= cmd_write_reg && cmd_config_reg; // [RL3]
    end else if (state_reg == ST_IDLE && !adv_wr_reg) begin
      user_write_reg <= QUAL_RESET;
      config_write_reg <= QUAL_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read path; full buffer holds back the advance strobe
  assign rd_adv = (state_reg == ST_READ) && fifo_in_ready;
  assign rd_push = rd_adv && backend_ready; // [RL14]
  assign rd_word = cmd_config_reg ? config_read_bus : backend_read_bus;

  read_word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rd_push),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(pci_rd_valid),
    .out_ready(pci_rd_ready),
    .out_data(pci_rd_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // error reporting; serr needs both enables in the command word
  assign serr_cause = pci_addr_perr && cmd_bit_eight_in && cmd_bit_six_in;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      perr_seen_reg <= QUAL_RESET;
      serr_reg <= QUAL_RESET;
      perr_out_reg <= QUAL_RESET;
    end else begin
      perr_seen_reg <= pci_addr_perr || pci_data_perr; // [RL8]
      serr_reg <= serr_cause; // [RL10]
      perr_out_reg <= pci_data_perr && cmd_bit_six_in;
    end
  end

  assign addr_wrdata_bus = bus_reg;
  assign addr_valid = addr_valid_reg;
  assign transfer_advance = adv_wr_reg || rd_adv;
  assign user_write = user_write_reg;
  assign config_write = config_write_reg;
  assign parity_error_seen = perr_seen_reg;
  // one flop feeds the pin and the status report so they never disagree
  assign pci_serr_out = serr_reg;
  assign system_error_signalled = serr_reg;
  assign pci_perr_out = perr_out_reg;

  //////////////////////////////////////////////////////////////////////////
  a_user_write_start: assert property (@(posedge clk) disable iff (!reset_n) // [RL1]
    (state_reg == ST_ADDR && cmd_write_reg && !cmd_config_reg && write_cmd_decoded)
    |=> user_write ##1 user_write)
    else $error("user write qualifier not raised at start");

  a_user_write_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RL1]
    (state_reg == ST_WRITE && user_write && !pci_end) |=> user_write)
    else $error("user write qualifier dropped mid transaction");

  a_config_write_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RL3]
    (state_reg == ST_WRITE && cmd_config_reg && !pci_end) |=> config_write && !user_write)
    else $error("config write qualifier not held");

  a_parity_seen: assert property (@(posedge clk) disable iff (!reset_n) // [RL8]
    (pci_addr_perr || pci_data_perr) |=> parity_error_seen)
    else $error("parity error not reported");

  a_serr_signalled: assert property (@(posedge clk) disable iff (!reset_n) // [RL10]
    (pci_addr_perr && cmd_bit_eight_in && cmd_bit_six_in)
    |=> pci_serr_out && system_error_signalled)
    else $error("system error driven but not signalled");

  a_write_data_strobe: assert property (@(posedge clk) disable iff (!reset_n) // [RL12]
    (state_reg == ST_WRITE && pci_data_valid)
    |=> transfer_advance && addr_wrdata_bus == $past(pci_wr_data))
    else $error("write data not strobed with advance");

  a_read_transfer: assert property (@(posedge clk) disable iff (!reset_n) // [RL14]
    (state_reg == ST_READ && transfer_advance && backend_ready) |=> pci_rd_valid)
    else $error("read transfer did not reach buffer");

  c_user_burst: cover property (@(posedge clk) disable iff (!reset_n)
    user_write && transfer_advance ##1 user_write && transfer_advance);
  c_config_write: cover property (@(posedge clk) disable iff (!reset_n)
    config_write && transfer_advance);
  c_read_stall: cover property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_READ && !fifo_in_ready);
  c_serr: cover property (@(posedge clk) disable iff (!reset_n) system_error_signalled);

endmodule : pci_target_backend_strobes

//--- pci_strobe_pkg.sv
// Purpose: shared constants and types for the pci back-end strobe block
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: command/status word lives in the back-end config logic, not here
package pci_strobe_pkg;

  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;

  // command and status words share one config dword
  localparam logic [7:0] CFG_CMD_STATUS_OFFSET = 8'h04;
  localparam int CMD_PARITY_RESP_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int STAT_SERR_BIT = 14;
  localparam int STAT_PERR_BIT = 15;

  localparam logic QUAL_RESET = 1'b0;
  localparam logic [DATA_W-1:0] BUS_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ADDR  = 4'h2,
    ST_WRITE = 4'h4,
    ST_READ  = 4'h8
  } xfer_state_t;

endpackage : pci_strobe_pkg

//--- read_word_fifo.sv
// Purpose: flop-based word fifo between back-end read data and the pci side
// Assumes: push and pop are qualified by in_ready and out_valid
// Notes: simultaneous push and pop on a full fifo is refused on the push side
`timescale 1ns/1ps
module read_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction : ptr_step

  assign in_ready = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : read_word_fifo

//--- backend_model.sv
// Purpose: back-end user logic and config-space logic facing the strobe block
// Assumes: one clock, synchronous active-low reset
// Notes: 16-word user store; command/status dword at config offset 04h
`timescale 1ns/1ps
module backend_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] addr_wrdata_bus,
  input wire logic addr_valid,
  input wire logic transfer_advance,
  input wire logic user_write,
  input wire logic config_write,
  input wire logic user_map,
  input wire logic stall,
  input wire logic parity_error_seen,
  input wire logic system_error_signalled,
  output logic write_cmd_decoded,
  output logic backend_ready,
  output logic [31:0] config_read_bus,
  output logic [31:0] backend_read_bus,
  output logic cmd_bit_six_in,
  output logic cmd_bit_eight_in,
  output logic [15:0] status_reg
);
  logic [15:0] command_reg;
  logic [31:0] mem_reg [16];
  logic [3:0] ptr_reg;
  logic cfg_wr;
  assign cfg_wr = transfer_advance & config_write;
  assign write_cmd_decoded = addr_valid & user_map;
  assign backend_ready = ~stall;
  assign backend_read_bus = mem_reg[ptr_reg];
  assign config_read_bus = {status_reg, command_reg};
  assign cmd_bit_six_in = command_reg[6];
  assign cmd_bit_eight_in = command_reg[8];
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_reg <= 4'h0;
      command_reg <= 16'h0000;
      status_reg <= 16'h0000;
    end else begin
      if (addr_valid)
        ptr_reg <= addr_wrdata_bus[5:2];
      else if (transfer_advance & (user_write | config_write | backend_ready))
        ptr_reg <= ptr_reg + 4'h1;
      if (transfer_advance & user_write)
        mem_reg[ptr_reg] <= addr_wrdata_bus;
      if (cfg_wr)
        command_reg <= addr_wrdata_bus[15:0];
      // set wins over a write-one clear in the same cycle
      status_reg[15] <= parity_error_seen | (status_reg[15] & ~(cfg_wr & addr_wrdata_bus[31]));
      status_reg[14] <= system_error_signalled | (status_reg[14] & ~(cfg_wr & addr_wrdata_bus[30]));
    end
  end
endmodule : backend_model

//--- pci_target_backend_strobes_test.sv
// Purpose: self-checking bench for the back-end strobe block
// Assumes: bench drives at falling edge, checks at the following falling edge
// Notes: read buffer is drained fully after every read, it is never flushed
`timescale 1ns/1ps
module pci_target_backend_strobes_test;
  import pci_strobe_pkg::*;
  logic clk, reset_n, pci_addr_phase, pci_cmd_is_write, pci_cmd_is_config, pci_data_valid;
  logic pci_end, pci_addr_perr, pci_data_perr, pci_serr_out, pci_perr_out, pci_rd_valid;
  logic pci_rd_ready, addr_valid, transfer_advance, user_write, config_write, user_map, stall;
  logic write_cmd_decoded, backend_ready, cmd_bit_six_in, cmd_bit_eight_in;
  logic parity_error_seen, system_error_signalled;
  logic [31:0] pci_addr_in, pci_wr_data, pci_rd_data, addr_wrdata_bus, config_read_bus;
  logic [31:0] backend_read_bus;
  logic [15:0] status_reg, ecmd, est;
  logic [31:0] em [16];
  int fail_count, total_checks, seed, cyc;
  pci_target_backend_strobes dut (.clk, .reset_n, .pci_addr_phase, .pci_addr_in,
    .pci_cmd_is_write, .pci_cmd_is_config, .pci_data_valid, .pci_wr_data, .pci_end,
    .pci_addr_perr, .pci_data_perr, .pci_serr_out, .pci_perr_out, .pci_rd_valid,
    .pci_rd_ready, .pci_rd_data, .addr_wrdata_bus, .addr_valid, .transfer_advance,
    .user_write, .config_write, .write_cmd_decoded, .backend_ready, .config_read_bus,
    .backend_read_bus, .cmd_bit_six_in, .cmd_bit_eight_in, .parity_error_seen,
    .system_error_signalled);
  backend_model far (.clk, .reset_n, .addr_wrdata_bus, .addr_valid, .transfer_advance,
    .user_write, .config_write, .user_map, .stall, .parity_error_seen,
    .system_error_signalled, .write_cmd_decoded, .backend_ready, .config_read_bus,
    .backend_read_bus, .cmd_bit_six_in, .cmd_bit_eight_in, .status_reg);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // whole run needs under 400 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  task results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task start(input logic [31:0] a, input logic w, input logic c);
    @(negedge clk);
    {pci_addr_phase, pci_addr_in, pci_cmd_is_write, pci_cmd_is_config} = {1'h1, a, w, c};
    user_map = w & ~c;
    @(negedge clk);
    pci_addr_phase = 1'h0;
    chk(addr_valid, 1'h1);
    chk(addr_wrdata_bus, a);
  endtask : start
  task wrt(input logic [31:0] a, input logic c, input int n, input logic [31:0] cd);
    logic [31:0] d;
    start(a, 1'h1, c);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      if (i > 0) begin
        chk(transfer_advance, 1'h1);
        chk(addr_wrdata_bus, d);
        chk(c ? config_write : user_write, 1'h1);
      end
      d = c ? cd : $random(seed);
      {pci_data_valid, pci_wr_data, pci_end} = {i < n, d, i == n - 1};
      if (i < n && c) begin
        ecmd = d[15:0];
        est = est & ~(d[31:16] & 16'hC000);
      end else if (i < n)
        em[(a[5:2] + i) % 16] = d;
    end
    repeat (2) @(negedge clk);
    chk({user_write, config_write}, 2'h0);
    $display("write test done");
  endtask : wrt
  task rd(input logic [31:0] a, input logic c, input int n);
    int k;
    start(a, 1'h0, c);
    repeat (n) @(negedge clk) stall = 1'($random(seed));
    // one more edge so stall is never assigned twice in one step
    @(negedge clk);
    {stall, pci_end} = 2'h1;
    if (!c) chk(transfer_advance, 1'h0);
    @(negedge clk);
    pci_end = 1'h0;
    pci_rd_ready = 1'h1;
    k = 0;
    while (pci_rd_valid === 1'h1 && k < 40) begin
      chk(pci_rd_data, c ? {est, ecmd} : em[(a[5:2] + k) % 16]);
      k++;
      @(negedge clk);
    end
    pci_rd_ready = 1'h0;
    if (!c) chk(k, 16);
    else chk(k == 0, 1'h0);
    $display("read test done");
  endtask : rd
  task err(input logic ap, input logic dp);
    @(negedge clk);
    {pci_addr_perr, pci_data_perr} = {ap, dp};
    @(negedge clk);
    {pci_addr_perr, pci_data_perr} = 2'h0;
    chk(parity_error_seen, ap | dp);
    chk(system_error_signalled, ap & ecmd[8] & ecmd[6]);
    chk(pci_serr_out, ap & ecmd[8] & ecmd[6]);
    chk(pci_perr_out, dp & ecmd[6]);
    est = est | {ap | dp, ap & ecmd[8] & ecmd[6], 14'h0000};
    $display("error test done");
  endtask : err
  initial begin
    {reset_n, pci_addr_phase, pci_cmd_is_write, pci_cmd_is_config, pci_data_valid} = 5'h00;
    {pci_end, pci_addr_perr, pci_data_perr, pci_rd_ready, user_map, stall} = 6'h00;
    {pci_addr_in, pci_wr_data, ecmd, est} = 96'h0;
    {fail_count, total_checks, seed, cyc} = {32'h0, 32'h0, 32'd93373, 32'h0};
    repeat (12) @(negedge clk);
    reset_n = 1'h1;
    wrt(32'h0000_0000, 1'h0, 16, 32'h0);
    rd(32'h0000_0000, 1'h0, 60);
    wrt(32'h0000_0004, 1'h1, 2, 32'hC000_0140);
    err(1'h1, 1'h0);
    err(1'h0, 1'h1);
    rd(32'h0000_0004, 1'h1, 6);
    wrt(32'h0000_0004, 1'h1, 1, 32'hC000_0040);
    err(1'h1, 1'h0);
    rd(32'h0000_0004, 1'h1, 6);
    results();
  end
endmodule : pci_target_backend_strobes_test
